// ### low_power_mode_controller.sv
// low power mode controller: stop and standby entry, wake and oscillator gating
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01: stop gates all clocks, pll and oscillators; ram and registers kept.
// RULE_02: in stop a wake-capable peripheral may turn the high speed internal osc on.
// RULE_03: regulator held in low-power mode during stop, never off.
// RULE_04: any external event line wakes stop; core resumes within 3.5 us.
// RULE_05: event line source: gpio, supply monitor, comparator 1 or 2 with reference on.
// RULE_06: usb, usart, i2c, low power serial and timer wakes also end stop.
// RULE_07: standby switches the regulator off, powering down the core, and the pll.
// RULE_08: standby with calendar keeps only the low speed oscillator running.
// RULE_09: standby without calendar switches every oscillator off.
// RULE_10: standby loses ram and registers; only standby domain registers kept.
// RULE_11: standby with calendar exits within 60 us on reset, watchdog, wake pin, calendar event.
// RULE_12: standby without calendar exits only on external reset or wake pin rise.
// RULE_13: calendar, watchdog and their clocks are not stopped by low power entry; both low speed oscillators are off in stop and bare standby.
// RULE_14: the lcd driver keeps running during stop.
// RULE_15: standby wake restarts the core like a reset.
// RULE_16: a wake during entry is not lost; the controller wakes once entry ends.
module low_power_mode_controller (
    // clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  sys_rst,
    // request from the core
    input  wire logic                                  lp_req,
    input  wire logic [1:0]                            lp_mode,
    input  wire logic                                  lse_select,
    // event line source selection
    input  wire logic [1:0]                            event_src_sel,
    input  wire logic [lpm_pkg::GPIO_LINES-1:0]        event_gpio_mask,
    input  wire logic                                  vref_on,
    // wake sources, asynchronous
    input  wire logic [lpm_pkg::GPIO_LINES-1:0]        gpio_in,
    input  wire logic                                  supply_monitor_output,
    input  wire logic                                  comp1_event,
    input  wire logic                                  comp2_event,
    input  wire logic [lpm_pkg::PERIPH_WAKE-1:0]       periph_wake,
    input  wire logic [lpm_pkg::PERIPH_WAKE-1:0]       periph_hsi_req,
    input  wire logic [lpm_pkg::WAKE_PINS-1:0]         wake_pin,
    input  wire logic                                  external_reset_pin_n,
    input  wire logic                                  independent_watchdog_rst,
    input  wire logic                                  cal_event,
    // power and clock controls
    output logic                                       core_clk_en,
    output logic                                       pll_en,
    output logic                                       multispeed_internal_osc_en,
    output logic                                       high_speed_internal_osc_en,
    output logic                                       high_speed_crystal_osc_en,
    output logic                                       low_speed_internal_osc_en,
    output logic                                       low_speed_crystal_osc_en,
    output logic                                       regulator_on,
    output logic                                       regulator_low_power,
    output logic                                       retain_core_state,
    output logic                                       lcd_run,
    output logic                                       calendar_run,
    output logic                                       watchdog_run,
    // core status
    output logic                                       core_rst,
    output logic                                       core_resume,
    output logic                                       in_stop,
    output logic                                       in_standby
);

    // ********************************************************************
    // input synchronisers
    // ********************************************************************
    localparam int unsigned SW = lpm_pkg::GPIO_LINES + lpm_pkg::PERIPH_WAKE * 2 + lpm_pkg::WAKE_PINS + 6;

    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] sync_next;

    always_comb begin
        sync_next = {gpio_in, supply_monitor_output, comp1_event, comp2_event, periph_wake,
                     periph_hsi_req, wake_pin, external_reset_pin_n, independent_watchdog_rst, cal_event};
    end

    // no reset on the stages: the reset cycles flush both before anything reads them
    always_ff @(posedge core_clk) begin
        sync1_reg <= sync_next;
        sync2_reg <= sync1_reg;
    end

    logic [lpm_pkg::GPIO_LINES-1:0]  s_gpio;
    logic                            s_supply;
    logic                            s_comp1;
    logic                            s_comp2;
    logic [lpm_pkg::PERIPH_WAKE-1:0] s_pwake;
    logic [lpm_pkg::PERIPH_WAKE-1:0] s_phsi;
    logic [lpm_pkg::WAKE_PINS-1:0]   s_wpin;
    logic                            s_external_reset_pin_n;
    logic                            s_wdg;
    logic                            s_cal;

    always_comb begin
        {s_gpio, s_supply, s_comp1, s_comp2, s_pwake, s_phsi, s_wpin, s_external_reset_pin_n, s_wdg, s_cal} = sync2_reg;
    end

    // ********************************************************************
    // wake detection
    // ********************************************************************
    logic [lpm_pkg::WAKE_PINS-1:0] wpin_prev_reg;
    logic [lpm_pkg::WAKE_PINS-1:0] wpin_prev_next;
    logic                          event_line;
    logic                          stop_wake;
    logic                          stby_wake;
    logic                          hsi_for_periph;
    // captured request mode, read by the wake decode as well as the sequencer
    logic [1:0]                    mode_reg;
    logic [1:0]                    mode_next;

    always_comb begin
        wpin_prev_next = s_wpin;
        // RULE_05 event source select
        unique case (event_src_sel)
            lpm_pkg::SRC_GPIO:   event_line = |(s_gpio & event_gpio_mask);
            lpm_pkg::SRC_SUPPLY: event_line = s_supply;
            lpm_pkg::SRC_COMP1:  event_line = s_comp1 & vref_on;
            lpm_pkg::SRC_COMP2:  event_line = s_comp2 & vref_on;
        endcase
        // RULE_04 RULE_06 stop wake sources
        stop_wake = event_line | (|s_pwake) | ~s_external_reset_pin_n | s_wdg;
        // RULE_11 RULE_12 standby wake set depends on calendar
        stby_wake = ~s_external_reset_pin_n | (|(s_wpin & ~wpin_prev_reg));
        // captured mode, so a late change of lp_mode cannot widen the wake set
        if (mode_reg == lpm_pkg::REQ_STANDBY_CAL) begin
            stby_wake = stby_wake | s_wdg | s_cal;
        end
        hsi_for_periph = |s_phsi;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wpin_prev_reg <= '0;
        end else begin
            wpin_prev_reg <= wpin_prev_next;
        end
    end

    // ********************************************************************
    // mode sequencer
    // ********************************************************************
    lpm_pkg::lpm_state_e state_reg;
    lpm_pkg::lpm_state_e state_next;
    logic [11:0]         cnt_reg;
    logic [11:0]         cnt_next;
    logic                pend_reg;
    logic                pend_next;
    logic                was_stby_reg;
    logic                was_stby_next;
    logic                wake_now;

    // stop against either standby flavour, decoded in several places
    function automatic logic mode_is_stop(input logic [1:0] mode);
        return mode == lpm_pkg::REQ_STOP;
    endfunction : mode_is_stop

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        mode_next     = mode_reg;
        pend_next     = pend_reg;
        was_stby_next = was_stby_reg;
        wake_now      = mode_is_stop(mode_reg) ? stop_wake : stby_wake;
        unique case (state_reg)
            lpm_pkg::RUN: begin
                // drop any pending wake left from an earlier entry
                pend_next = 1'b0;
                if (lp_req) begin
                    state_next = lpm_pkg::ENTERING;
                    mode_next  = lp_mode;
                    cnt_next   = lpm_pkg::ENTRY_CYC;
                end
            end
            lpm_pkg::ENTERING: begin
                // RULE_16 remember a wake seen mid-entry
                if (wake_now) begin
                    pend_next = 1'b1;
                end
                if (cnt_reg != lpm_pkg::CNT_ZERO) begin
                    cnt_next = cnt_reg - 12'h001;
                end else if (pend_reg | wake_now) begin
                    state_next    = lpm_pkg::EXITING;
                    was_stby_next = ~mode_is_stop(mode_reg);
                    cnt_next      = mode_is_stop(mode_reg) ? lpm_pkg::STOP_EXIT_CYC
                                                           : lpm_pkg::STANDBY_EXIT_CYC;
                end else begin
                    state_next = mode_is_stop(mode_reg) ? lpm_pkg::STOP : lpm_pkg::STANDBY;
                end
            end
            lpm_pkg::STOP: begin
                if (stop_wake) begin
                    state_next    = lpm_pkg::EXITING;
                    was_stby_next = 1'b0;
                    cnt_next      = lpm_pkg::STOP_EXIT_CYC;
                end
            end
            lpm_pkg::STANDBY: begin
                if (stby_wake) begin
                    state_next    = lpm_pkg::EXITING;
                    was_stby_next = 1'b1;
                    cnt_next      = lpm_pkg::STANDBY_EXIT_CYC;
                end
            end
            // clocks are back at once; the count only delays resume or the reset release
            lpm_pkg::EXITING: begin
                if (cnt_reg != lpm_pkg::CNT_ZERO) begin
                    cnt_next = cnt_reg - 12'h001;
                end else begin
                    state_next = lpm_pkg::RUN;
                end
            end
            default: begin
                state_next = lpm_pkg::RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg    <= lpm_pkg::RUN;
            cnt_reg      <= lpm_pkg::CNT_ZERO;
            mode_reg     <= lpm_pkg::REQ_STOP;
            pend_reg     <= 1'b0;
            was_stby_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            mode_reg     <= mode_next;
            pend_reg     <= pend_next;
            was_stby_reg <= was_stby_next;
        end
    end

    // ********************************************************************
    // registered power and clock controls
    // ********************************************************************
    logic [16:0] ctl_reg;
    logic [16:0] ctl_next;
    logic        deep;
    logic        stop_st;
    logic        stby_st;
    logic        stby_cal;
    logic        lsc_keep;
    logic        exit_done;

    always_comb begin
        stop_st   = (state_next == lpm_pkg::STOP);
        stby_st   = (state_next == lpm_pkg::STANDBY);
        deep      = stop_st | stby_st;
        stby_cal  = stby_st & (mode_reg == lpm_pkg::REQ_STANDBY_CAL);
        lsc_keep  = ~stop_st & ~(stby_st & ~stby_cal);
        exit_done = (state_reg == lpm_pkg::EXITING) & (state_next == lpm_pkg::RUN);
        ctl_next = {
            // RULE_01 core clock, pll and fast oscillators gated
            ~deep,
            // RULE_07 pll off
            ~deep,
            ~deep,
            // RULE_02 peripheral may borrow the fast internal osc in stop
            ~deep | (stop_st & hsi_for_periph),
            ~deep,
            // RULE_08 RULE_09 low speed oscillator kept except in stop and bare standby
            lsc_keep & ~lse_select,
            lsc_keep & lse_select,
            // RULE_03 RULE_07 regulator low power in stop, off in standby
            ~stby_st,
            stop_st,
            // RULE_10 core state kept outside standby
            ~stby_st,
            // RULE_14 lcd left alone by stop; it has no supply in standby
            ~stby_st,
            // RULE_13 calendar and watchdog never stopped by entry
            1'b1,
            1'b1,
            // RULE_15 standby wake held in reset until exit ends
            stby_st | ((state_next == lpm_pkg::EXITING) & was_stby_next),
            // RULE_04 resume pulse after a stop exit
            exit_done & ~was_stby_reg,
            stop_st,
            stby_st
        };
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // run values, so no false low power indication leaks out of reset
            ctl_reg <= lpm_pkg::CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    always_comb begin
        {core_clk_en, pll_en, multispeed_internal_osc_en, high_speed_internal_osc_en,
         high_speed_crystal_osc_en, low_speed_internal_osc_en, low_speed_crystal_osc_en,
         regulator_on, regulator_low_power, retain_core_state, lcd_run, calendar_run,
         watchdog_run, core_rst, core_resume, in_stop, in_standby} = ctl_reg;
    end

endmodule : low_power_mode_controller

`default_nettype wire

// ### lpm_pkg.sv
// constants shared by the low power mode controller
package lpm_pkg;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int unsigned CLK_PERIOD_PS    = 40000;
    // stop wake latency, printed in nanoseconds (3.5 us)
    localparam int unsigned STOP_WAKE_NS     = 3500;
    localparam int unsigned STANDBY_WAKE_US  = 60;
    // longest times round down, never below one cycle
    localparam int unsigned STOP_WAKE_CYC_RAW    = (STOP_WAKE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned STOP_WAKE_CYC        = (STOP_WAKE_CYC_RAW < 1) ? 1 : STOP_WAKE_CYC_RAW;
    localparam int unsigned STANDBY_WAKE_CYC_RAW = (STANDBY_WAKE_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned STANDBY_WAKE_CYC     = (STANDBY_WAKE_CYC_RAW < 1) ? 1 : STANDBY_WAKE_CYC_RAW;
    // controller answers in a fixed sequence well inside both limits
    localparam logic [11:0] ENTRY_CYC        = 12'h004;
    localparam logic [11:0] STOP_EXIT_CYC    = 12'h008;
    localparam logic [11:0] STANDBY_EXIT_CYC = 12'h020;
    localparam logic [11:0] CNT_ZERO         = 12'h000;
    // control word after reset, in output order; the internal low speed osc stands in for the crystal
    localparam logic [16:0] CTL_RESET        = 17'h1FAF0;

    // ********************************************************************
    // sizes and encodings
    // ********************************************************************
    localparam int unsigned GPIO_LINES  = 16;
    localparam int unsigned WAKE_PINS   = 3;
    localparam int unsigned PERIPH_WAKE = 5;
    // periph wake bit order: usb, usart, i2c, low_power_serial_port, low_power_timer
    localparam logic [1:0] SRC_GPIO   = 2'h0;
    localparam logic [1:0] SRC_SUPPLY = 2'h1;
    localparam logic [1:0] SRC_COMP1  = 2'h2;
    localparam logic [1:0] SRC_COMP2  = 2'h3;

    // requested low power mode
    localparam logic [1:0] REQ_STOP         = 2'h0;
    localparam logic [1:0] REQ_STANDBY_CAL  = 2'h1;
    localparam logic [1:0] REQ_STANDBY_BARE = 2'h2;

    typedef enum logic [2:0] {
        RUN, ENTERING, STOP, STANDBY, EXITING
    } lpm_state_e;

endpackage : lpm_pkg

// ### lpm_wake_model.sv
// wake source, reset pin and watchdog model driving the controller's asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_model (
    // clock
    input  wire logic        core_clk,
    // wake sources and reset pin
    output logic [15:0]      gpio_in,
    output logic             supply_monitor_output,
    output logic             comp1_event,
    output logic             comp2_event,
    output logic [4:0]       periph_wake,
    output logic [4:0]       periph_hsi_req,
    output logic [2:0]       wake_pin,
    output logic             external_reset_pin_n,
    output logic             independent_watchdog_rst,
    output logic             cal_event
);
    // one bit per source: 0-15 gpio, 16 supply, 17-18 comparators, 19-23 peripherals,
    // 24-26 wake pins, 27 reset pin, 28 watchdog, 29 calendar, 30-34 oscillator requests
    logic [34:0] src = 35'h0;
    logic        rst_act;
    assign {periph_hsi_req, cal_event, independent_watchdog_rst, rst_act, wake_pin, periph_wake,
            comp2_event, comp1_event, supply_monitor_output, gpio_in} = src;
    assign external_reset_pin_n = ~rst_act;

    // held three cycles so the two-flop synchroniser always catches it
    task automatic fire(input int n);
        @(negedge core_clk);
        src[n] = 1'b1;
        repeat (3) @(negedge core_clk);
        src[n] = 1'b0;
    endtask : fire
endmodule : lpm_wake_model
`default_nettype wire

// ### low_power_mode_controller_asserts.sv
// concurrent checks on the low power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_asserts (
    // clock, reset and mode
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        lse_select,
    input  wire logic        external_reset_pin_n,
    input  wire logic [1:0]  lp_mode,
    input  wire logic [2:0]  wake_pin,
    // controls and status
    input  wire logic        core_clk_en,
    input  wire logic        pll_en,
    input  wire logic        multispeed_internal_osc_en,
    input  wire logic        high_speed_internal_osc_en,
    input  wire logic        high_speed_crystal_osc_en,
    input  wire logic        low_speed_internal_osc_en,
    input  wire logic        low_speed_crystal_osc_en,
    input  wire logic        regulator_on,
    input  wire logic        regulator_low_power,
    input  wire logic        retain_core_state,
    input  wire logic        lcd_run,
    input  wire logic        calendar_run,
    input  wire logic        watchdog_run,
    input  wire logic        core_rst,
    input  wire logic        core_resume,
    input  wire logic        in_stop,
    input  wire logic        in_standby
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // cycles the core is held in reset after leaving standby
    logic [10:0] exit_cnt_reg;
    logic [10:0] exit_cnt_next;
    always_comb exit_cnt_next = (core_rst && !in_standby) ? exit_cnt_reg + 11'h001 : 11'h000;
    always_ff @(posedge core_clk) exit_cnt_reg <= sys_rst ? 11'h000 : exit_cnt_next;

    stop_clocks_off_a: assert property (in_stop |-> !core_clk_en && !pll_en && !multispeed_internal_osc_en
        && !high_speed_crystal_osc_en && !low_speed_internal_osc_en && !low_speed_crystal_osc_en && retain_core_state)
        else $error("clock or oscillator left running in stop");
    stop_regulator_lp_a: assert property (in_stop |-> regulator_on && regulator_low_power)
        else $error("regulator not in low power mode in stop");
    stop_keeps_lcd_a: assert property (in_stop |-> lcd_run && calendar_run && watchdog_run)
        else $error("display, calendar or watchdog stopped in stop");
    standby_power_off_a: assert property (in_standby |->
        !regulator_on && !pll_en && !retain_core_state && core_rst)
        else $error("core domain still powered in standby");
    standby_cal_osc_a: assert property (in_standby && lp_mode == lpm_pkg::REQ_STANDBY_CAL |->
        !multispeed_internal_osc_en && !high_speed_internal_osc_en && !high_speed_crystal_osc_en
        && (lse_select ? low_speed_crystal_osc_en : low_speed_internal_osc_en))
        else $error("wrong oscillators in standby with calendar");
    standby_bare_osc_a: assert property (in_standby && lp_mode == lpm_pkg::REQ_STANDBY_BARE |->
        !(multispeed_internal_osc_en || high_speed_internal_osc_en || high_speed_crystal_osc_en
        || low_speed_internal_osc_en || low_speed_crystal_osc_en)) else $error("oscillator on in bare standby");
    stop_wake_time_a: assert property ($fell(in_stop) |-> ##[1:86] core_resume)
        else $error("core not resumed in time after stop");
    standby_exit_time_a: assert property (exit_cnt_reg < 11'h5DC)
        else $error("standby exit too slow");
    bare_stays_asleep_a: assert property ((wake_pin == 3'h0 && external_reset_pin_n)[*6]
        ##0 (in_standby && lp_mode == lpm_pkg::REQ_STANDBY_BARE) |=> in_standby) else $error("bare standby left");
    cover property ($rose(in_stop));
    cover property ($rose(in_standby));
    cover property (core_resume);
endmodule : low_power_mode_controller_asserts
bind low_power_mode_controller low_power_mode_controller_asserts low_power_mode_controller_asserts_i (.*);
`default_nettype wire

// ### low_power_mode_controller_tb.sv
// self-checking testbench for the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_tb;
    logic        core_clk = 1'b0, sys_rst = 1'b1, lp_req = 1'b0, lse_select = 1'b0, vref_on = 1'b0;
    logic [1:0]  lp_mode = 2'h0, event_src_sel = 2'h0;
    logic [15:0] event_gpio_mask = 16'h0000, gpio_in;
    logic [4:0]  periph_wake, periph_hsi_req;
    logic [2:0]  wake_pin;
    logic        supply_monitor_output, comp1_event, comp2_event, external_reset_pin_n;
    logic        independent_watchdog_rst, cal_event, core_clk_en, pll_en, multispeed_internal_osc_en;
    logic        high_speed_internal_osc_en, high_speed_crystal_osc_en, low_speed_internal_osc_en;
    logic        low_speed_crystal_osc_en, regulator_on, regulator_low_power, retain_core_state, lcd_run;
    logic        calendar_run, watchdog_run, core_rst, core_resume, in_stop, in_standby;
    int          fail_count = 0, check_count = 0, cycles = 0;
    int          stop_src[$] = '{0, 16, 17, 18, 19, 20, 21, 22, 23, 27, 28};
    int          sb_src[$] = '{0, 16, 19, 24, 25, 26, 27, 28, 29};

    low_power_mode_controller low_power_mode_controller_i (.*);
    lpm_wake_model lpm_wake_model_i (.*);

    always #20 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // the whole run needs well under half this
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            give_verdict();
        end
    end

    // reference wake decision for a source in a mode
    function automatic logic exp_wake(input int m, input int n);
        if (m != 0) return n >= 24 && (n <= 27 || m == 1);
        if (n < 16) return event_src_sel == lpm_pkg::SRC_GPIO && event_gpio_mask[n];
        if (n == 16) return event_src_sel == lpm_pkg::SRC_SUPPLY;
        if (n == 17) return event_src_sel == lpm_pkg::SRC_COMP1 && vref_on;
        if (n == 18) return event_src_sel == lpm_pkg::SRC_COMP2 && vref_on;
        return 1'b1;
    endfunction : exp_wake

    task automatic trial(input int m, input int n, input bit early);
        int   lim;
        logic woke;
        lim = (m == 0) ? 87 : 1500;
        woke = 1'b0;
        @(negedge core_clk);
        lp_mode = m[1:0];
        lp_req = 1'b1;
        @(negedge core_clk);
        lp_req = 1'b0;
        if (!early) begin
            repeat (6) @(negedge core_clk);
            check({core_clk_en, regulator_on, retain_core_state, in_stop, in_standby},
                  (m == 0) ? 5'h0E : 5'h01);
            check({low_speed_crystal_osc_en, low_speed_internal_osc_en},
                  (m == 1) ? (lse_select ? 2'h2 : 2'h1) : 2'h0);
            check({pll_en, multispeed_internal_osc_en, high_speed_crystal_osc_en,
                   high_speed_internal_osc_en, regulator_low_power}, (m == 0) ? 5'h01 : 5'h00);
            check({lcd_run, calendar_run, watchdog_run}, (m == 0) ? 3'h7 : 3'h3);
            if (m == 0) begin
                lpm_wake_model_i.src[30 + n % 5] = 1'b1;
                repeat (4) @(negedge core_clk);
                check(high_speed_internal_osc_en, 1'b1);
                lpm_wake_model_i.src[30 + n % 5] = 1'b0;
                repeat (4) @(negedge core_clk);
                check(high_speed_internal_osc_en, 1'b0);
            end
        end
        fork
            lpm_wake_model_i.fire(n);
        join_none
        for (int i = 0; i < lim && !woke; i++) begin
            @(negedge core_clk);
            woke = (m == 0) ? core_resume : !core_rst;
        end
        check(woke, early ? 1'b1 : exp_wake(m, n));
        if (!woke) lpm_wake_model_i.fire(27);
        for (int i = 0; i < 1500 && (core_rst || in_stop || in_standby); i++) @(negedge core_clk);
        check({in_stop, in_standby, core_rst}, 3'h0);
        repeat (12) @(negedge core_clk);
    endtask : trial

    task automatic shuffle();
        event_src_sel = 2'($urandom);
        event_gpio_mask = 16'($urandom);
        vref_on = 1'($urandom);
        lse_select = 1'($urandom);
    endtask : shuffle

    initial begin
        void'($urandom(32'h6011));
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        check({core_clk_en, regulator_on, low_speed_crystal_osc_en, in_stop, in_standby, core_rst}, 6'h30);
        trial(0, 19, 1'b1);
        foreach (stop_src[i]) begin
            for (int r = 0; r < 2; r++) begin
                shuffle();
                trial(0, (stop_src[i] == 0) ? int'($urandom_range(15)) : stop_src[i], 1'b0);
            end
        end
        for (int m = 1; m < 3; m++) begin
            foreach (sb_src[i]) begin
                shuffle();
                trial(m, sb_src[i], 1'b0);
            end
        end
        give_verdict();
    end
endmodule : low_power_mode_controller_tb
`default_nettype wire
